// file: hw/pfce_pkg.sv
// Purpose: Shared constants and carriers for the payload and command port.
// Assumes: 40 MHz system clock, 115200 bit/s serial link, 8N1 framing.
// Notes:   AXI4-Lite register offsets are byte addresses.
package pfce_pkg;
	localparam int unsigned CLK_HZ         = 40000000;
	localparam int unsigned BAUD_BPS       = 115200;
	localparam int unsigned BIT_CYCLES     = CLK_HZ / BAUD_BPS;
	localparam int unsigned HALF_CYCLES    = BIT_CYCLES / 2;
	localparam int unsigned DATA_BITS      = 8;

	// Entry pattern, acknowledge and command-line characters.
	localparam logic [7:0] ENTRY_LEAD      = 8'hFF;
	localparam logic [7:0] ENTRY_MARK      = 8'hFB;
	localparam logic [7:0] ENTRY_TAIL      = 8'h2B;
	localparam int unsigned ENTRY_LEAD_N   = 5;
	localparam int unsigned ENTRY_LEN      = 8;
	localparam logic [7:0] ACK_CHAR0       = 8'h43;
	localparam logic [7:0] ACK_CHAR1       = 8'h4D;
	localparam logic [7:0] CHAR_CR         = 8'h0D;
	localparam logic [7:0] CHAR_LF         = 8'h0A;

	// Register byte offsets.
	localparam logic [7:0] REG_CTRL        = 8'h00;
	localparam logic [7:0] REG_STATUS      = 8'h04;
	localparam logic [7:0] REG_LON_IN      = 8'h08;
	localparam logic [7:0] REG_LON_OUT     = 8'h0C;
	localparam logic [7:0] REG_COUNTS      = 8'h10;
	localparam logic [7:0] REG_CMD_DATA    = 8'h14;

	// Control register fields (all write one pulses; exit acts only in command mode).
	localparam int unsigned CTRL_TX_CYCLE  = 0;
	localparam int unsigned CTRL_UL_INC    = 1;
	localparam int unsigned CTRL_DL_INC    = 2;
	localparam int unsigned CTRL_EXIT      = 3;
	localparam int unsigned CTRL_CLR_CNT   = 4;

	// Status register fields.
	localparam int unsigned ST_CMD_MODE    = 0;
	localparam int unsigned ST_PENDING     = 1;
	localparam int unsigned ST_DISPLAY     = 2;
	localparam int unsigned ST_CMD_VALID   = 3;
	localparam int unsigned ST_START_TX    = 4;

	localparam logic [1:0] RESP_OKAY       = 2'h0;
	localparam logic [1:0] RESP_SLVERR     = 2'h2;

	// Longitude in decimal digits, one nibble each.
	typedef struct packed {
		logic [3:0] deg_hund;
		logic [3:0] deg_tens;
		logic [3:0] deg_unit;
		logic [3:0] min_tens;
		logic [3:0] min_unit;
		logic [3:0] frac_tenth;
		logic [3:0] frac_hund;
		logic       west;
	} pfce_lon_s;

	// One command-line byte with its end-of-line marker.
	typedef struct packed {
		logic [7:0] data;
		logic       eol;
	} pfce_cmd_s;
endpackage

// file: hw/pfce_top.sv
// Purpose: Longitude packing, frame counts and serial command-mode entry.
// Assumes: Host keeps 115200 8N1 framing; rxd and inputs sync to aclk.
// Notes:   AXI4-Lite reads answer one cycle after acceptance, writes two cycles after.
`timescale 1ns/1ps
module pfce_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        tx_cycle_active,
	input  wire logic        rxd,
	output logic             txd,
	output logic             display_cmd_screen,
	output logic             start_tx_cycle
);
	typedef enum logic [1:0] {IDLE, START, DATA, STOP} pfce_bit_e;

	// Receiver state.
	pfce_bit_e              rx_st_reg;
	logic [15:0]            rx_cnt_reg;
	logic [2:0]             rx_bit_reg;
	logic [7:0]             rx_sh_reg;
	logic                   rx_done_reg;
	// Transmitter state.
	pfce_bit_e              tx_st_reg;
	logic [15:0]            tx_cnt_reg;
	logic [2:0]             tx_bit_reg;
	logic [7:0]             tx_sh_reg;
	logic                   txd_reg;
	logic [1:0]             ack_left_reg;
	// Command-mode state.
	logic [3:0]             match_reg;
	logic                   pending_reg;
	logic                   cmd_mode_reg;
	logic                   start_tx_reg;
	logic                   last_cr_reg;
	// Registers.
	pfce_pkg::pfce_lon_s    lon_reg;
	logic [7:0]             uplink_frame_count_reg;
	logic [7:0]             downlink_frame_count_reg;
	// Two-entry command buffer.
	pfce_pkg::pfce_cmd_s    buf_mem [2];
	logic                   buf_wp_reg;
	logic                   buf_rp_reg;
	logic [1:0]             buf_n_reg;
	// Bus state.
	logic                   aw_got_reg;
	logic                   w_got_reg;
	logic [7:0]             aw_addr_reg;
	logic [31:0]            w_data_reg;
	logic                   bvalid_reg;
	logic                   rvalid_reg;
	logic [31:0]            rdata_reg;
	logic [1:0]             rresp_reg;
	logic [1:0]             bresp_reg;

	// Receiver decode: a full bit period, or half while finding mid-start.
	wire logic        rx_tick   = rx_cnt_reg == 16'(pfce_pkg::BIT_CYCLES - 1);
	wire logic        rx_half   = rx_cnt_reg == 16'(pfce_pkg::HALF_CYCLES - 1);
	wire logic [7:0]  rx_byte   = rx_sh_reg;
	wire logic [7:0]  want_byte = (match_reg < 4'(pfce_pkg::ENTRY_LEAD_N))
		? pfce_pkg::ENTRY_LEAD
		: (match_reg == 4'(pfce_pkg::ENTRY_LEAD_N)) ? pfce_pkg::ENTRY_MARK
		: pfce_pkg::ENTRY_TAIL;
	wire logic        hit       = rx_byte == want_byte;
	wire logic        hit_first = rx_byte == pfce_pkg::ENTRY_LEAD;
	wire logic        entry_seen = rx_done_reg && hit
		&& match_reg == 4'(pfce_pkg::ENTRY_LEN - 1);
	wire logic        enter_now = pending_reg && tx_cycle_active;

	// Command-line bytes: CR marks end of line, LF after CR is dropped.
	wire logic        is_cr     = rx_byte == pfce_pkg::CHAR_CR;
	wire logic        is_lf     = rx_byte == pfce_pkg::CHAR_LF;
	wire logic        cmd_byte  = rx_done_reg && cmd_mode_reg
		&& !(is_lf && last_cr_reg);
	wire logic        buf_wr    = cmd_byte && buf_n_reg != 2'd2;

	// Transmitter decode.
	wire logic        tx_tick   = tx_cnt_reg == 16'(pfce_pkg::BIT_CYCLES - 1);
	wire logic        tx_load   = tx_st_reg == IDLE && ack_left_reg != 2'd0;
	wire logic [7:0]  ack_char  = (ack_left_reg == 2'd2)
		? pfce_pkg::ACK_CHAR0 : pfce_pkg::ACK_CHAR1;

	// Bus decode.
	wire logic        wr_go     = aw_got_reg && w_got_reg && !bvalid_reg;
	wire logic        wr_ctrl   = wr_go && aw_addr_reg == pfce_pkg::REG_CTRL;
	wire logic        wr_lon    = wr_go && aw_addr_reg == pfce_pkg::REG_LON_IN;
	wire logic        wr_ok     = aw_addr_reg == pfce_pkg::REG_CTRL
		|| aw_addr_reg == pfce_pkg::REG_LON_IN;
	wire logic        rd_go     = s_axi_arvalid && !rvalid_reg;
	wire logic        rd_cmd    = rd_go
		&& s_axi_araddr == pfce_pkg::REG_CMD_DATA;
	wire logic        buf_rd    = rd_cmd && buf_n_reg != 2'd0;
	wire logic        ctl_tx    = wr_ctrl && w_data_reg[pfce_pkg::CTRL_TX_CYCLE];
	wire logic        ctl_ul    = wr_ctrl && w_data_reg[pfce_pkg::CTRL_UL_INC];
	wire logic        ctl_dl    = wr_ctrl && w_data_reg[pfce_pkg::CTRL_DL_INC];
	wire logic        ctl_exit  = wr_ctrl && w_data_reg[pfce_pkg::CTRL_EXIT]
		&& cmd_mode_reg;
	wire logic        ctl_clr   = wr_ctrl && w_data_reg[pfce_pkg::CTRL_CLR_CNT];

	// Packed longitude bytes, most significant first.
	wire logic [31:0] lon_packed = {lon_reg.deg_hund, lon_reg.deg_tens,
		lon_reg.deg_unit, lon_reg.min_tens,
		lon_reg.min_unit, lon_reg.frac_tenth,
		lon_reg.frac_hund, 3'b000, lon_reg.west};

	// Read data selection.
	pfce_pkg::pfce_cmd_s buf_head;
	assign buf_head = buf_mem[buf_rp_reg];
	wire logic [31:0] status_word = {27'h0, start_tx_reg,
		buf_n_reg != 2'd0, cmd_mode_reg, pending_reg, cmd_mode_reg};
	wire logic [31:0] rd_word =
		(s_axi_araddr == pfce_pkg::REG_STATUS) ? status_word
		: (s_axi_araddr == pfce_pkg::REG_LON_IN) ? {3'h0, lon_reg}
		: (s_axi_araddr == pfce_pkg::REG_LON_OUT) ? lon_packed
		: (s_axi_araddr == pfce_pkg::REG_COUNTS)
			? {16'h0, downlink_frame_count_reg, uplink_frame_count_reg}
		: (s_axi_araddr == pfce_pkg::REG_CMD_DATA)
			? {22'h0, buf_n_reg != 2'd0, buf_head}
		: 32'h0;
	wire logic        rd_ok = s_axi_araddr == pfce_pkg::REG_CTRL
		|| s_axi_araddr == pfce_pkg::REG_STATUS
		|| s_axi_araddr == pfce_pkg::REG_LON_IN
		|| s_axi_araddr == pfce_pkg::REG_LON_OUT
		|| s_axi_araddr == pfce_pkg::REG_COUNTS
		|| s_axi_araddr == pfce_pkg::REG_CMD_DATA;

	// Bus handshake outputs.
	assign s_axi_awready      = !aw_got_reg;
	assign s_axi_wready       = !w_got_reg;
	assign s_axi_bvalid       = bvalid_reg;
	assign s_axi_bresp        = bresp_reg;
	assign s_axi_arready      = !rvalid_reg;
	assign s_axi_rvalid       = rvalid_reg;
	assign s_axi_rdata        = rdata_reg;
	assign s_axi_rresp        = rresp_reg;
	assign txd                = txd_reg;
	assign display_cmd_screen = cmd_mode_reg;
	assign start_tx_cycle     = start_tx_reg;

	// Serial receiver, 8 data bits, no parity, one stop bit.
	always_ff @(posedge aclk) begin
		rx_done_reg <= 1'b0;
		if (!aresetn) begin
			rx_st_reg  <= IDLE;
			rx_cnt_reg <= 16'h0;
			rx_bit_reg <= 3'h0;
			rx_sh_reg  <= 8'h0;
		end else begin
			rx_cnt_reg <= rx_cnt_reg + 16'h1;
			case (rx_st_reg)
				IDLE: begin
					rx_cnt_reg <= 16'h0;
					if (!rxd) rx_st_reg <= START;
				end
				START: if (rx_half) begin
					rx_cnt_reg <= 16'h0;
					rx_bit_reg <= 3'h0;
					rx_st_reg  <= rxd ? IDLE : DATA;
				end
				DATA: if (rx_tick) begin
					rx_cnt_reg <= 16'h0;
					rx_sh_reg  <= {rxd, rx_sh_reg[7:1]};
					rx_bit_reg <= rx_bit_reg + 3'h1;
					if (rx_bit_reg == 3'(pfce_pkg::DATA_BITS - 1))
						rx_st_reg <= STOP;
				end
				STOP: if (rx_tick) begin
					rx_st_reg   <= IDLE;
					rx_done_reg <= rxd;
				end
			endcase
		end
	end

	// Entry pattern match; a miss rechecks the byte at position one.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			match_reg <= 4'h0;
		end else if (rx_done_reg && !cmd_mode_reg) begin
			if (entry_seen) match_reg <= 4'h0;
			else if (hit) match_reg <= match_reg + 4'h1;
			else match_reg <= {3'h0, hit_first};
		end
	end

	// Command mode: pending request, entry, exit and start pulse.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pending_reg  <= 1'b0;
			cmd_mode_reg <= 1'b0;
			start_tx_reg <= 1'b0;
		end else begin
			start_tx_reg <= ctl_exit || (ctl_tx && !cmd_mode_reg);
			if (entry_seen && !cmd_mode_reg) pending_reg <= 1'b1;
			else if (enter_now) pending_reg <= 1'b0;
			if (enter_now) cmd_mode_reg <= 1'b1;
			else if (ctl_exit) cmd_mode_reg <= 1'b0;
		end
	end

	// Command bytes into the two-entry buffer for software to read.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			buf_wp_reg  <= 1'b0;
			buf_rp_reg  <= 1'b0;
			buf_n_reg   <= 2'd0;
			last_cr_reg <= 1'b0;
		end else begin
			if (rx_done_reg) last_cr_reg <= is_cr;
			if (buf_wr) begin
				buf_mem[buf_wp_reg] <= '{data: rx_byte, eol: is_cr};
				buf_wp_reg <= !buf_wp_reg;
			end
			if (buf_rd) buf_rp_reg <= !buf_rp_reg;
			buf_n_reg <= buf_n_reg + 2'(buf_wr) - 2'(buf_rd);
		end
	end

	// Acknowledge transmitter, two characters after entry.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_st_reg    <= IDLE;
			tx_cnt_reg   <= 16'h0;
			tx_bit_reg   <= 3'h0;
			tx_sh_reg    <= 8'h0;
			txd_reg      <= 1'b1;
			ack_left_reg <= 2'd0;
		end else begin
			tx_cnt_reg <= tx_tick ? 16'h0 : tx_cnt_reg + 16'h1;
			if (enter_now) ack_left_reg <= 2'd2;
			else if (tx_load) ack_left_reg <= ack_left_reg - 2'd1;
			case (tx_st_reg)
				IDLE: if (tx_load) begin
					tx_sh_reg  <= ack_char;
					tx_cnt_reg <= 16'h0;
					txd_reg    <= 1'b0;
					tx_st_reg  <= DATA;
					tx_bit_reg <= 3'h0;
				end
				DATA: if (tx_tick) begin
					txd_reg    <= tx_sh_reg[tx_bit_reg];
					tx_bit_reg <= tx_bit_reg + 3'h1;
					if (tx_bit_reg == 3'(pfce_pkg::DATA_BITS - 1))
						tx_st_reg <= STOP;
				end
				STOP: if (tx_tick) begin
					txd_reg   <= 1'b1;
					tx_st_reg <= START;
				end
				START: if (tx_tick) tx_st_reg <= IDLE;
			endcase
		end
	end

	// Longitude digits and the two frame counts.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lon_reg      <= '0;
			uplink_frame_count_reg <= 8'h0;
			downlink_frame_count_reg <= 8'h0;
		end else begin
			if (wr_lon) lon_reg <= w_data_reg[28:0];
			if (ctl_clr) begin
				uplink_frame_count_reg <= 8'h0;
				downlink_frame_count_reg <= 8'h0;
			end else begin
				if (ctl_ul) uplink_frame_count_reg <= uplink_frame_count_reg + 8'h1;
				if (ctl_dl) downlink_frame_count_reg <= downlink_frame_count_reg + 8'h1;
			end
		end
	end

	// AXI4-Lite write channel; address and data taken in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg  <= 1'b0;
			w_got_reg   <= 1'b0;
			aw_addr_reg <= 8'h0;
			w_data_reg  <= 32'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= pfce_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_got_reg) begin
				aw_got_reg  <= 1'b1;
				aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && !w_got_reg) begin
				w_got_reg  <= 1'b1;
				w_data_reg <= s_axi_wdata;
			end
			if (wr_go) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= wr_ok ? pfce_pkg::RESP_OKAY
					: pfce_pkg::RESP_SLVERR;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
				aw_got_reg <= 1'b0;
				w_got_reg  <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0;
			rresp_reg  <= pfce_pkg::RESP_OKAY;
		end else if (rd_go) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_word;
			rresp_reg  <= rd_ok ? pfce_pkg::RESP_OKAY : pfce_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end
endmodule // pfce_top

// file: dv/pfce_host.sv
// Purpose: Host terminal model on the far side of the serial port.
// Assumes: 8N1 frames at the package bit time, idle line high.
// Notes:   Bytes sent back by the block pile up in rx_q.
`timescale 1ns/1ps
module pfce_host (
	input  wire logic aclk,
	output logic      rxd,
	input  wire logic txd
);
	localparam int unsigned BIT = pfce_pkg::BIT_CYCLES;
	logic [7:0] rx_q [$];
	logic [7:0] sh;

	// The line idles at the mark level between frames.
	initial rxd = 1'h1;

	// Sends one frame: start bit, data LSB first, one stop bit.
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'h1, b, 1'h0};
		for (int i = 0; i < 10; i++) begin
			rxd <= fr[i];
			repeat (BIT) @(posedge aclk);
		end
	endtask

	// Samples each returned frame in the middle of every data bit.
	always begin
		@(negedge txd);
		repeat (BIT / 2) @(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge aclk);
			sh[i] = txd;
		end
		repeat (BIT) @(posedge aclk);
		rx_q.push_back(sh);
	end
endmodule // pfce_host

// file: dv/pfce_top_asserts.sv
// Purpose: Concurrent checks on the pins of the payload and command port.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ps
module pfce_top_asserts (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        tx_cycle_active,
	input wire logic        rxd,
	input wire logic        txd,
	input wire logic        display_cmd_screen,
	input wire logic        start_tx_cycle
);
	localparam int unsigned BIT = pfce_pkg::BIT_CYCLES;
	logic        txd_q;
	int unsigned run;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Counts how long txd has held its present level.
	always_ff @(posedge aclk) begin
		txd_q <= aresetn ? txd : 1'h1;
		run   <= (!aresetn || txd != txd_q) ? 1 : run + 1;
	end

	// Mode entry, acknowledge and exit against their causes.
	a_entry_in_tx: assert property ($rose(display_cmd_screen)
		|-> $past(tx_cycle_active)) else $error("entry outside tx cycle");
	a_ack_starts: assert property ($rose(display_cmd_screen)
		|-> ##[0:20] !txd) else $error("no acknowledge after entry");
	a_ack_in_cmd: assert property ($fell(txd)
		|-> display_cmd_screen) else $error("txd active outside mode");
	a_bit_time: assert property (txd && !txd_q
		|-> run % BIT == 0) else $error("low run not whole bits");
	a_exit_starts: assert property ($fell(display_cmd_screen)
		|-> ##[0:1] (start_tx_cycle || $past(start_tx_cycle)))
		else $error("exit without tx start");
	a_start_pulse: assert property (start_tx_cycle
		|=> !start_tx_cycle) else $error("start pulse too long");

	// Read answers come on time; read and write answers hold until taken.
	a_read_turn: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("late read answer");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
	a_write_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
endmodule // pfce_top_asserts

bind pfce_top pfce_top_asserts pfce_top_asserts_i (.*);

// file: dv/tb_pfce_top.sv
// Purpose: Self-checking bench for the payload and command port.
// Assumes: 40 MHz clock, host model on the serial pins.
// Notes:   Longitude rows run in a loop, serial cases by hand.
`timescale 1ns/1ps
module tb_pfce_top;
	typedef struct packed {
		logic [27:0] dig;
		logic        west;
		logic [31:0] exp;
	} pfce_row_s;
	localparam pfce_row_s ROWS [3] = '{
		'{28'h1795999, 1'h1, 32'h17959991},
		'{28'h0053450, 1'h0, 32'h00534500},
		'{28'h1234567, 1'h1, 32'h12345671}};
	localparam logic [7:0] PAT [15] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'hFB, 8'h2B, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFB, 8'h2B, 8'h2B};
	localparam logic [7:0] CMD [4] = '{8'h41, 8'h0D, 8'h0A, 8'h42};
	logic        aclk = 1'h0;
	logic        aresetn = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic        s_axi_rready = 1'h0, tx_cycle_active = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, txd, rxd, display_cmd_screen, start_tx_cycle;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	int          n_fail = 0, n_compared = 0, n_start = 0, k;

	pfce_top pfce_top_i (.*);
	pfce_host pfce_host_i (
		.aclk (aclk),
		.rxd  (rxd),
		.txd  (txd)
	);

	// Clock and a count of start pulses.
	always #12.5 aclk = ~aclk;
	always @(negedge aclk) n_start += int'(start_tx_cycle === 1'h1);

	// Compares one value and reports a mismatch.
	task automatic chk(input string n, input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", n, e, s);
		end
	endtask

	// One bus write; address and data are released as each is taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aw, w, b;
		b = 1'h0;
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= v;
		s_axi_wstrb   <= 4'hF;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid  <= 1'h1;
		s_axi_bready  <= 1'h1;
		for (int t = 0; t < 99 && !b; t++) begin
			@(negedge aclk);
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			b = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'h0;
			if (w) s_axi_wvalid <= 1'h0;
			if (b) s_axi_bready <= 1'h0;
		end
		if (!b) n_fail++;
	endtask

	// One bus read; data and response are taken with rvalid.
	task automatic rd(input logic [7:0] a);
		logic ar, rv;
		rv = 1'h0;
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready  <= 1'h1;
		for (int t = 0; t < 99 && !rv; t++) begin
			@(negedge aclk);
			ar = s_axi_arvalid & s_axi_arready;
			rv = s_axi_rvalid;
			d = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge aclk);
			if (ar) s_axi_arvalid <= 1'h0;
			if (rv) s_axi_rready <= 1'h0;
		end
		if (!rv) n_fail++;
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic finish_test;
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Main sequence.
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		chk("idle", 32'({txd, display_cmd_screen, start_tx_cycle}), 32'h4);
		foreach (ROWS[i]) begin
			wr(pfce_pkg::REG_LON_IN, {3'h0, ROWS[i].dig, ROWS[i].west});
			rd(pfce_pkg::REG_LON_OUT);
			chk("lon_out", d, ROWS[i].exp);
			rd(pfce_pkg::REG_LON_IN);
			chk("lon_in", d, {3'h0, ROWS[i].dig, ROWS[i].west});
		end
		// A late rready must find the read answer held.
		@(posedge aclk);
		s_axi_araddr  <= pfce_pkg::REG_LON_OUT;
		s_axi_arvalid <= 1'h1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		repeat (3) @(posedge aclk);
		s_axi_rready  <= 1'h1;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready  <= 1'h0;
		chk("late_rd", s_axi_rdata, 32'h12345671);
		// A late bready must find the write answer held.
		s_axi_awaddr  <= pfce_pkg::REG_CTRL;
		s_axi_wdata   <= 32'h0;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid  <= 1'h1;
		do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
		s_axi_awvalid <= 1'h0;
		s_axi_wvalid  <= 1'h0;
		repeat (3) @(posedge aclk);
		s_axi_bready  <= 1'h1;
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready  <= 1'h0;
		chk("late_wr", 32'(s_axi_bresp), 32'(pfce_pkg::RESP_OKAY));
		wr(8'h18, 32'h1);
		chk("wr_resp", 32'(resp), 32'(pfce_pkg::RESP_SLVERR));
		rd(8'h18);
		chk("rd_resp", 32'(resp), 32'(pfce_pkg::RESP_SLVERR));
		// Uplink count to its top, then a wrap beside a downlink step.
		wr(pfce_pkg::REG_CTRL, 32'h10);
		for (int i = 0; i < 255; i++) wr(pfce_pkg::REG_CTRL, 32'h2);
		rd(pfce_pkg::REG_COUNTS);
		chk("counts", 32'(d[15:0]), 32'h00FF);
		wr(pfce_pkg::REG_CTRL, 32'h6);
		wr(pfce_pkg::REG_CTRL, 32'h4);
		rd(pfce_pkg::REG_COUNTS);
		chk("counts", 32'(d[15:0]), 32'h0200);
		// Broken pattern whose breaking byte starts the real one.
		foreach (PAT[i]) pfce_host_i.send_byte(PAT[i]);
		rd(pfce_pkg::REG_STATUS);
		chk("pending", 32'(d[4:0]), 32'h02);
		tx_cycle_active <= 1'h1;
		for (int t = 0; t < 9 && display_cmd_screen !== 1'h1; t++)
			@(negedge aclk);
		chk("display", 32'(display_cmd_screen), 32'h1);
		@(posedge aclk);
		tx_cycle_active <= 1'h0;
		for (int t = 0; t < 9000 && pfce_host_i.rx_q.size() < 2; t++)
			@(posedge aclk);
		chk("ack", 32'({pfce_host_i.rx_q[0], pfce_host_i.rx_q[1]}), 32'h434D);
		// Command text: the buffer fills, LF and the last byte are dropped.
		foreach (CMD[i]) pfce_host_i.send_byte(CMD[i]);
		rd(pfce_pkg::REG_STATUS);
		chk("status_cmd", 32'(d[4:0]), 32'h0D);
		rd(pfce_pkg::REG_CMD_DATA);
		chk("cmd_a", 32'(d[9:0]), 32'h282);
		rd(pfce_pkg::REG_CMD_DATA);
		chk("cmd_cr", 32'(d[9:0]), 32'h21B);
		rd(pfce_pkg::REG_CMD_DATA);
		chk("cmd_empty", 32'(d[9]), 32'h0);
		k = n_start;
		wr(pfce_pkg::REG_CTRL, 32'h1);
		wr(pfce_pkg::REG_CTRL, 32'h8);
		repeat (3) @(posedge aclk);
		chk("exit", 32'({n_start - k, display_cmd_screen}), 32'h2);
		wr(pfce_pkg::REG_CTRL, 32'h1);
		repeat (3) @(posedge aclk);
		chk("tx_start", 32'(n_start - k), 32'h2);
		finish_test();
	end

	// Cuts a hang short well past the expected run length.
	initial begin
		repeat (95000) @(posedge aclk);
		n_fail++;
		finish_test();
	end
endmodule // tb_pfce_top
